// File: rtl/aate_top.sv
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
module aate_top #(
  parameter int CNT_W = 24,
  parameter int DIV_W = 24
)(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [5:0] PFL_IN,
  input wire logic [7:0] TRIG_BUS_IN,
  input wire logic STAR_IN,
  input wire logic CTR_OUT_IN,
  input wire logic START_TRIG_I,
  output logic START_TRIG_O,
  output logic START_TRIG_OE,
  input wire logic REF_TRIG_IN,
  output logic SAMPLE_PULSE,
  output logic CONV_PULSE,
  output logic ACQ_ACTIVE
);

  // Counters must fit the 32-bit data bus and hold a useful ratio
  if (CNT_W < 2 || CNT_W > 32 || DIV_W < 2 || DIV_W > 32)
  begin : g_bad_width
    $error("aate_top: CNT_W and DIV_W must lie in 2..32");
  end

  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam logic [DIV_W-1:0] DIV_ONE = {{(DIV_W-1){1'b0}}, 1'b1};

  aate_conv_if #(.DIV_W(DIV_W)) cv ();

  // Bus side state
  logic wr_phase_q;
  logic rd_wait_q;
  logic [7:0] addr_q;
  logic ready_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_mux;
  logic addr_take;

  // Software visible registers
  logic [aate_pkg::CTRL_W-1:0] ctrl_q;
  logic [DIV_W-1:0] samp_div_q;
  logic [DIV_W-1:0] conv_div_q;
  logic [7:0] nchan_q;
  logic [CNT_W-1:0] post_q;
  logic [CNT_W-1:0] pre_q;
  logic done_q;
  logic cmd_start_q;
  logic cmd_stop_q;
  logic sw_pulse_q;

  // Synchronisers and edge detection
  logic [aate_pkg::EXT_W-1:0] ext_m_q;
  logic [aate_pkg::EXT_W-1:0] ext_s_q;
  logic lvl_prev_q;
  logic start_prev_q;
  logic ref_prev_q;

  // Acquisition core
  aate_pkg::aate_state_t state_q;
  aate_pkg::aate_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [DIV_W-1:0] div_cnt_q;
  logic div_pulse_q;
  logic samp_q;
  logic strig_q;
  logic finish;
  logic src_level;
  logic active_q;

  // Field decode
  wire logic falling = ctrl_q[aate_pkg::CTRL_FALL_BIT];
  wire logic [2:0] src = ctrl_q[aate_pkg::CTRL_SRC_LSB +: aate_pkg::CTRL_SRC_W];
  wire logic [2:0] idx = ctrl_q[aate_pkg::CTRL_IDX_LSB +: aate_pkg::CTRL_IDX_W];
  wire logic [1:0] mode = ctrl_q[aate_pkg::CTRL_MODE_LSB +: aate_pkg::CTRL_MODE_W];
  wire logic sw_start = ctrl_q[aate_pkg::CTRL_SWSTART_BIT];
  wire logic wr_en = wr_phase_q;
  wire logic [31:0] wd = HWDATA;

  // Address phase capture; reads get one wait state so a write just ahead is seen
  assign addr_take = HSEL && HTRANS[1] && HREADY;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wr_phase_q <= 1'b0;
      rd_wait_q <= 1'b0;
      addr_q <= 8'h00;
      ready_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wr_phase_q <= addr_take && HWRITE;
      rd_wait_q <= addr_take && !HWRITE;
      ready_q <= !(addr_take && !HWRITE);
      if (addr_take)
        addr_q <= {HADDR[7:2], 2'b00};
      if (rd_wait_q)
        rdata_q <= rdata_mux;
    end
  end

  assign HREADYOUT = ready_q;
  assign HRDATA = rdata_q;
  assign HRESP = 1'b0;

  // Read selection; unmapped offsets and the command register read zero
  assign rdata_mux =
    (addr_q == aate_pkg::OFS_CTRL) ? 32'(ctrl_q) :
    (addr_q == aate_pkg::OFS_SAMP_DIV) ? 32'(samp_div_q) :
    (addr_q == aate_pkg::OFS_CONV_DIV) ? 32'(conv_div_q) :
    (addr_q == aate_pkg::OFS_NCHAN) ? 32'(nchan_q) :
    (addr_q == aate_pkg::OFS_POST) ? 32'(post_q) :
    (addr_q == aate_pkg::OFS_PRE) ? 32'(pre_q) :
    (addr_q == aate_pkg::OFS_STATUS) ? {24'h000000, cv.busy, done_q, state_q} :
    (addr_q == aate_pkg::OFS_COUNT) ? 32'(cnt_q) : 32'h00000000;

  // Register writes and one-cycle command strobes
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ctrl_q <= aate_pkg::CTRL_RST;
      samp_div_q <= DIV_W'(aate_pkg::SAMP_DIV_RST);
      conv_div_q <= DIV_W'(aate_pkg::CONV_DEFAULT_CYC);
      nchan_q <= 8'(aate_pkg::NCHAN_RST);
      post_q <= CNT_W'(aate_pkg::POST_RST);
      pre_q <= CNT_W'(aate_pkg::PRE_RST);
      cmd_start_q <= 1'b0;
      cmd_stop_q <= 1'b0;
      sw_pulse_q <= 1'b0;
    end
    else
    begin
      cmd_start_q <= wr_en && (addr_q == aate_pkg::OFS_CMD) && wd[aate_pkg::CMD_START_BIT];
      cmd_stop_q <= wr_en && (addr_q == aate_pkg::OFS_CMD) && wd[aate_pkg::CMD_STOP_BIT];
      sw_pulse_q <= wr_en && (addr_q == aate_pkg::OFS_CMD) && wd[aate_pkg::CMD_SWPULSE_BIT];
      if (wr_en && addr_q == aate_pkg::OFS_CTRL)
        ctrl_q <= wd[aate_pkg::CTRL_W-1:0];
      if (wr_en && addr_q == aate_pkg::OFS_SAMP_DIV)
        samp_div_q <= wd[DIV_W-1:0];
      if (wr_en && addr_q == aate_pkg::OFS_CONV_DIV)
        conv_div_q <= wd[DIV_W-1:0];
      if (wr_en && addr_q == aate_pkg::OFS_NCHAN)
        nchan_q <= wd[7:0];
      if (wr_en && addr_q == aate_pkg::OFS_POST)
        post_q <= wd[CNT_W-1:0];
      if (wr_en && addr_q == aate_pkg::OFS_PRE)
        pre_q <= wd[CNT_W-1:0];
    end
  end

  // Two-stage synchronisers for every pin input except CTR_OUT_IN, then edge history
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ext_m_q <= '0;
      ext_s_q <= '0;
      lvl_prev_q <= 1'b0;
      start_prev_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end
    else
    begin
      ext_m_q <= {REF_TRIG_IN, START_TRIG_I, STAR_IN, TRIG_BUS_IN, PFL_IN};
      ext_s_q <= ext_m_q;
      lvl_prev_q <= src_level;
      start_prev_q <= ext_s_q[aate_pkg::EXT_START_BIT];
      ref_prev_q <= ext_s_q[aate_pkg::EXT_REF_BIT];
    end
  end

  // Sample source selection; an out-of-range line index gives a quiet source
  wire logic pfl_lvl = (idx < 3'(aate_pkg::NUM_PFL)) ? ext_s_q[idx] : 1'b0;
  wire logic bus_lvl = ext_s_q[5'(aate_pkg::EXT_BUS_LSB) + {2'b00, idx}];
  assign src_level =
    (src == aate_pkg::SRC_CTR) ? CTR_OUT_IN :
    (src == aate_pkg::SRC_DIV) ? div_pulse_q :
    (src == aate_pkg::SRC_SW) ? sw_pulse_q :
    (src == aate_pkg::SRC_PFL) ? pfl_lvl :
    (src == aate_pkg::SRC_BUS) ? bus_lvl :
    (src == aate_pkg::SRC_STAR) ? ext_s_q[aate_pkg::EXT_STAR_BIT] : 1'b0;

  // Edge of interest and acceptance gating
  wire logic edge_hit = falling ? (!src_level && lvl_prev_q) : (src_level && !lvl_prev_q);
  wire logic running = (state_q == aate_pkg::ST_PRE) || (state_q == aate_pkg::ST_ARMED) ||
                       (state_q == aate_pkg::ST_POST) || (state_q == aate_pkg::ST_CONT);
  wire logic accepted = running && edge_hit && !cv.busy;
  wire logic start_edge = ext_s_q[aate_pkg::EXT_START_BIT] && !start_prev_q;
  wire logic ref_edge = ext_s_q[aate_pkg::EXT_REF_BIT] && !ref_prev_q;
  wire logic launch = ((state_q == aate_pkg::ST_IDLE) && cmd_start_q && sw_start) ||
                      ((state_q == aate_pkg::ST_WAIT) && start_edge);

  // Timebase divider runs only while an acquisition uses it
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      div_cnt_q <= '0;
      div_pulse_q <= 1'b0;
    end
    else if (!running || src != aate_pkg::SRC_DIV)
    begin
      div_cnt_q <= samp_div_q - DIV_ONE;
      div_pulse_q <= 1'b0;
    end
    else if (div_cnt_q == '0)
    begin
      div_cnt_q <= samp_div_q - DIV_ONE;
      div_pulse_q <= 1'b1;
    end
    else
    begin
      div_cnt_q <= div_cnt_q - DIV_ONE;
      div_pulse_q <= 1'b0;
    end
  end

  // Acquisition sequencing and sample counter
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    finish = 1'b0;
    unique case (state_q)
      aate_pkg::ST_IDLE:
        if (cmd_start_q && !sw_start)
          state_d = aate_pkg::ST_WAIT;
      aate_pkg::ST_WAIT:
        ;
      aate_pkg::ST_PRE:
        if (accepted)
        begin
          cnt_d = cnt_q - CNT_ONE;
          if (cnt_q <= CNT_ONE)
          begin
            state_d = aate_pkg::ST_ARMED;
            cnt_d = post_q;
          end
        end
      aate_pkg::ST_ARMED:
        if (ref_edge)
          state_d = aate_pkg::ST_POST;
      aate_pkg::ST_POST:
        if (accepted)
        begin
          cnt_d = cnt_q - CNT_ONE;
          if (cnt_q <= CNT_ONE)
          begin
            state_d = aate_pkg::ST_IDLE;
            cnt_d = '0;
            finish = 1'b1;
          end
        end
      aate_pkg::ST_CONT:
        ;
      default:
        state_d = aate_pkg::ST_IDLE;
    endcase
    if (launch)
    begin
      if (mode == aate_pkg::MODE_CONT)
        state_d = aate_pkg::ST_CONT;
      else if (mode == aate_pkg::MODE_PRE)
      begin
        state_d = (pre_q == '0) ? aate_pkg::ST_ARMED : aate_pkg::ST_PRE;
        cnt_d = (pre_q == '0) ? post_q : pre_q;
      end
      else
      begin
        state_d = aate_pkg::ST_POST;
        cnt_d = post_q;
      end
    end
    if (cmd_stop_q)
      state_d = aate_pkg::ST_IDLE;
  end

  // State, done flag and outward strobes
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q <= aate_pkg::ST_IDLE;
      cnt_q <= '0;
      done_q <= 1'b0;
      samp_q <= 1'b0;
      strig_q <= 1'b0;
      active_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      samp_q <= accepted;
      strig_q <= launch && sw_start;
      active_q <= (state_d != aate_pkg::ST_IDLE); // Pin straight from a flop, same timing as the state
      if (finish)
        done_q <= 1'b1;
      else if (cmd_start_q)
        done_q <= 1'b0;
    end
  end

  // Conversion pacing is handed every accepted sample
  assign cv.start = accepted;
  assign cv.ratio = conv_div_q;
  assign cv.nchan = nchan_q;

  aate_conv_pacer #(.DIV_W(DIV_W)) u_pacer (
    .clk(CLK),
    .rst_n(RSTN),
    .cv(cv.pacer)
  );

  assign SAMPLE_PULSE = samp_q;
  assign CONV_PULSE = cv.conv;
  assign START_TRIG_O = strig_q;
  assign START_TRIG_OE = strig_q;
  assign ACQ_ACTIVE = active_q;

endmodule

// File: rtl/aate_pkg.sv
package aate_pkg;

  // Clock and conversion timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int FASTEST_CONV_NS = 4000;
  localparam int SETTLE_PAD_NS = 10000;
  localparam int CONV_DEFAULT_CYC = (FASTEST_CONV_NS + SETTLE_PAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_SAMP_DIV = 8'h08;
  localparam logic [7:0] OFS_CONV_DIV = 8'h0C;
  localparam logic [7:0] OFS_NCHAN = 8'h10;
  localparam logic [7:0] OFS_POST = 8'h14;
  localparam logic [7:0] OFS_PRE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_COUNT = 8'h20;

  // Control register fields
  localparam int CTRL_W = 11;
  localparam int CTRL_FALL_BIT = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam int CTRL_IDX_LSB = 4;
  localparam int CTRL_MODE_LSB = 7;
  localparam int CTRL_SWSTART_BIT = 9;
  localparam int CTRL_SRC_W = 3;
  localparam int CTRL_IDX_W = 3;
  localparam int CTRL_MODE_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h202;

  // Command register bits
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_SWPULSE_BIT = 2;

  // Sample pulse sources
  localparam logic [2:0] SRC_CTR = 3'h0;
  localparam logic [2:0] SRC_DIV = 3'h1;
  localparam logic [2:0] SRC_SW = 3'h2;
  localparam logic [2:0] SRC_PFL = 3'h3;
  localparam logic [2:0] SRC_BUS = 3'h4;
  localparam logic [2:0] SRC_STAR = 3'h5;

  // Synchronised external line layout
  localparam int NUM_PFL = 6;
  localparam int NUM_BUS = 8;
  localparam int EXT_W = NUM_PFL + NUM_BUS + 3;
  localparam int EXT_BUS_LSB = NUM_PFL;
  localparam int EXT_STAR_BIT = NUM_PFL + NUM_BUS;
  localparam int EXT_START_BIT = EXT_STAR_BIT + 1;
  localparam int EXT_REF_BIT = EXT_STAR_BIT + 2;

  // Acquisition modes
  localparam logic [1:0] MODE_POST = 2'h0;
  localparam logic [1:0] MODE_PRE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;

  // Reset values of the data registers
  localparam int SAMP_DIV_RST = 100;
  localparam int NCHAN_RST = 1;
  localparam int POST_RST = 1;
  localparam int PRE_RST = 0;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WAIT = 6'h02,
    ST_PRE = 6'h04,
    ST_ARMED = 6'h08,
    ST_POST = 6'h10,
    ST_CONT = 6'h20
  } aate_state_t;

endpackage

// File: rtl/aate_conv_if.sv
`timescale 1ns/1ns
interface aate_conv_if #(parameter int DIV_W = 24);
  logic start;
  logic [DIV_W-1:0] ratio;
  logic [7:0] nchan;
  logic conv;
  logic busy;

  modport ctl (output start, output ratio, output nchan, input conv, input busy);
  modport pacer (input start, input ratio, input nchan, output conv, output busy);
endinterface

// File: rtl/aate_conv_pacer.sv
`timescale 1ns/1ns
module aate_conv_pacer #(parameter int DIV_W = 24)(
  input wire logic clk,
  input wire logic rst_n,
  aate_conv_if.pacer cv
);

  logic [DIV_W-1:0] cnt_q;
  logic [7:0] left_q;
  logic busy_q;
  logic conv_q;
  logic [DIV_W-1:0] reload;
  logic tick;

  // Divider reloads with ratio-1 so a pulse falls every ratio cycles
  assign reload = cv.ratio - {{(DIV_W-1){1'b0}}, 1'b1};
  assign tick = busy_q && (cnt_q == '0);
  assign cv.conv = conv_q;
  assign cv.busy = busy_q;

  // Count down, pulse, reload until every channel of the sample is converted
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      left_q <= 8'h00;
      busy_q <= 1'b0;
      conv_q <= 1'b0;
    end
    else
    begin
      conv_q <= tick;
      if (cv.start && !busy_q)
      begin
        cnt_q <= reload;
        left_q <= cv.nchan;
        busy_q <= (cv.nchan != 8'h00);
      end
      else if (tick)
      begin
        cnt_q <= reload;
        left_q <= left_q - 8'h01;
        busy_q <= (left_q != 8'h01);
      end
      else if (busy_q)
        cnt_q <= cnt_q - {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// File: bench/aate_monitor.sv
`timescale 1ns/1ns
module aate_monitor (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic START_TRIG_O,
  input wire logic START_TRIG_OE,
  input wire logic SAMPLE_PULSE,
  input wire logic CONV_PULSE,
  input wire logic ACQ_ACTIVE
);
  logic wr_q;
  logic [7:0] ofs_q;
  logic [31:0] cdiv_q, nch_q, gap_q, n_q;
  wire take = HSEL && HTRANS[1] && HREADY;
  // Shadow of the pacing setup, so gaps are judged against what software set
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      wr_q <= 1'b0;
      ofs_q <= 8'h00;
      cdiv_q <= 32'(aate_pkg::CONV_DEFAULT_CYC);
      nch_q <= 32'(aate_pkg::NCHAN_RST);
      gap_q <= 32'h0;
      n_q <= 32'h0;
    end
    else
    begin
      wr_q <= take && HWRITE;
      ofs_q <= HADDR[7:0];
      if (wr_q && ofs_q == aate_pkg::OFS_CONV_DIV)
        cdiv_q <= HWDATA;
      if (wr_q && ofs_q == aate_pkg::OFS_NCHAN)
        nch_q <= HWDATA;
      gap_q <= (SAMPLE_PULSE || CONV_PULSE) ? 32'h1 : gap_q + 32'h1;
      n_q <= SAMPLE_PULSE ? 32'h0 : n_q + 32'(CONV_PULSE);
    end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // A read holds the bus for exactly one wait cycle
  sequence rd_take;
    take && !HWRITE;
  endsequence
  sequence rd_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  read_wait_a: assert property (rd_take |=> rd_wait) else $error("read wait wrong");
  write_nowait_a: assert property (take && HWRITE |=> HREADYOUT) else $error("write stalled");
  resp_okay_a: assert property (HRESP == 1'b0) else $error("error response");
  trig_drive_a: assert property (START_TRIG_OE == START_TRIG_O) else $error("start drive bad");
  trig_launch_a: assert property (START_TRIG_O |-> $rose(ACQ_ACTIVE) ##1 !START_TRIG_O)
    else $error("start pulse bad");
  idle_sample_a: assert property (SAMPLE_PULSE |-> $past(ACQ_ACTIVE)) else $error("sample when idle");
  sample_hold_a: assert property (SAMPLE_PULSE && nch_q != 0 |=> !SAMPLE_PULSE [*2])
    else $error("sample in burst");
  conv_gap_a: assert property (CONV_PULSE |-> gap_q == cdiv_q) else $error("conversion gap");
  conv_count_a: assert property (CONV_PULSE |-> n_q < nch_q) else $error("extra conversion");
endmodule
bind aate_top aate_monitor mon_u (
  .CLK, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY, .HREADYOUT,
  .HRESP, .START_TRIG_O, .START_TRIG_OE, .SAMPLE_PULSE, .CONV_PULSE, .ACQ_ACTIVE
);

// File: bench/aate_ext_model.sv
`timescale 1ns/1ns
module aate_ext_model (
  input wire logic clk,
  input wire logic conv,
  input wire logic trig_o,
  input wire logic trig_oe,
  output logic [17:0] lines,
  output logic start_line,
  output int conv_cnt,
  output int strig_cnt
);
  // Trigger and clock lines idle low until a scenario moves them
  initial
    lines = 18'h0;
  // Shared start line: the engine's drive wins only while enabled
  assign start_line = trig_oe ? trig_o : lines[16];
  // Front end converts once per pulse; engine start pulses are tallied
  always @(posedge clk)
  begin
    if (conv === 1'b1)
      conv_cnt++;
    if (trig_oe === 1'b1 && trig_o === 1'b1)
      strig_cnt++;
  end
  // Held 41 cycles, well past the synchroniser, so like edges of a strobe lie 82 cycles apart
  task automatic set_line(input int k, input logic v);
    @(posedge clk);
    lines[k] <= v;
    repeat (40)
      @(posedge clk);
  endtask
  task automatic strobe(input int k);
    set_line(k, 1'b1);
    set_line(k, 1'b0);
  endtask
endmodule

// File: bench/test_aate_top.sv
`timescale 1ns/1ns
module test_aate_top;
  logic CLK, RSTN, HSEL, HWRITE, HREADYOUT, HRESP, START_TRIG_O, START_TRIG_OE;
  logic SAMPLE_PULSE, CONV_PULSE, ACQ_ACTIVE, start_line;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [17:0] lines;
  int conv_cnt, strig_cnt, n_samp, cyc, last_s, samp_gap, miscompares, n_checks;
  aate_top dut_u (
    .CLK, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT),
    .HRDATA, .HREADYOUT, .HRESP, .PFL_IN(lines[5:0]), .TRIG_BUS_IN(lines[13:6]),
    .STAR_IN(lines[14]), .CTR_OUT_IN(lines[15]), .START_TRIG_I(start_line), .START_TRIG_O,
    .START_TRIG_OE, .REF_TRIG_IN(lines[17]), .SAMPLE_PULSE, .CONV_PULSE, .ACQ_ACTIVE
  );
  aate_ext_model ext_u (
    .clk(CLK), .conv(CONV_PULSE), .trig_o(START_TRIG_O), .trig_oe(START_TRIG_OE),
    .lines, .start_line, .conv_cnt, .strig_cnt
  );
  always #50 CLK = ~CLK;
  // Tally accepted samples and the spacing of the last two
  always @(posedge CLK)
  begin
    cyc++;
    if (SAMPLE_PULSE === 1'b1)
    begin
      n_samp++;
      samp_gap = cyc - last_s;
      last_s = cyc;
    end
  end
  task automatic print_verdict;
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic miss(input string m);
    miscompares++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic guard(input bit t);
    if (t)
    begin
      miss("timeout");
      print_verdict();
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    n_checks++;
    if (got !== e)
      miss($sformatf("word %h, wanted %h", got, e));
  endtask
  task automatic cnt(input int got, input int e);
    n_checks++;
    if (got != e)
      miss($sformatf("count %0d, wanted %0d", got, e));
  endtask
  // Ready is sampled at the edge itself; no fixed latency assumed
  task automatic rdy(inout int n);
    do
      @(posedge CLK);
    while (HREADYOUT !== 1'b1 && ++n < 99);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    rdy(n);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= d;
    rdy(n);
    q = HRDATA;
    guard(n >= 99);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Trailing conversions of the last sample run on for up to two padded periods after idle
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (3)
      @(posedge CLK);
    while (ACQ_ACTIVE !== 1'b0 && ++n < 3000)
      @(posedge CLK);
    guard(n >= 3000);
    repeat (300)
      @(posedge CLK);
  endtask
  task automatic poke(input int k);
    if (k == 16)
      wr(8'h04, 32'h4);
    else
      ext_u.strobe(k);
  endtask
  task automatic s_regs;
    rd(8'h00, 32'h202);
    rd(8'h08, 32'h64);
    rd(8'h0C, 32'h8C);
    rd(8'h10, 32'h1);
    rd(8'h14, 32'h1);
    rd(8'h18, 32'h0);
    rd(8'h1C, 32'h1);
    wr(8'h3C, 32'hFFFF);
    rd(8'h3C, 32'h0);
    wr(8'h1C, 32'h3F);
    rd(8'h1C, 32'h1);
  endtask
  task automatic s_post;
    int s0, c0, t0;
    wr(8'h08, 32'h12C);
    wr(8'h0C, 32'h8C);
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h3);
    s0 = n_samp;
    c0 = conv_cnt;
    t0 = strig_cnt;
    wr(8'h04, 32'h1);
    wait_idle();
    cnt(n_samp - s0, 3);
    cnt(samp_gap, 300);
    cnt(conv_cnt - c0, 6);
    cnt(strig_cnt - t0, 1);
    rd(8'h1C, 32'h41);
  endtask
  // Every source except the divider, and every index, odd ones on the falling edge
  task automatic s_src;
    int s0;
    wr(8'h14, 32'h1);
    wr(8'h10, 32'h1);
    wr(8'h0C, 32'h3C);
    for (int k = 0; k < 17; k++)
    begin
      wr(8'h00, {23'h1, aate_pkg::MODE_CONT, 3'(k < 6 ? k : k - 6),
        k < 6 ? 3'h3 : k < 14 ? 3'h4 : k == 14 ? 3'h5 : k == 15 ? 3'h0 : 3'h2, k[0]});
      s0 = n_samp;
      poke(k);
      cnt(n_samp - s0, 0);
      wr(8'h04, 32'h1);
      poke((k + 1) % 17);
      cnt(n_samp - s0, 0);
      if (k < 16)
      begin
        ext_u.set_line(k, 1'b1);
        cnt(n_samp - s0, k % 2 ? 0 : 1);
        ext_u.set_line(k, 1'b0);
      end
      else
      begin
        wr(8'h04, 32'h4);
        // Strobe, acceptance and the registered pulse land two edges after the write
        repeat (3)
          @(posedge CLK);
      end
      cnt(n_samp - s0, 1);
      chk({31'h0, ACQ_ACTIVE}, 32'h1);
      wr(8'h04, 32'h2);
      repeat (3)
        @(posedge CLK);
      chk({31'h0, ACQ_ACTIVE}, 32'h0);
    end
  endtask
  // Hardware start, early reference ignored, then armed and finished
  task automatic s_pre;
    int t0;
    wr(8'h18, 32'h1);
    wr(8'h14, 32'h2);
    wr(8'h00, {23'h0, aate_pkg::MODE_PRE, 3'h0, 3'h3, 1'b0});
    t0 = strig_cnt;
    wr(8'h04, 32'h1);
    ext_u.strobe(0);
    rd(8'h1C, 32'h2);
    ext_u.strobe(16);
    rd(8'h1C, 32'h4);
    rd(8'h20, 32'h1);
    ext_u.strobe(17);
    ext_u.strobe(0);
    rd(8'h1C, 32'h8);
    rd(8'h20, 32'h2);
    ext_u.strobe(0);
    rd(8'h20, 32'h2);
    ext_u.strobe(17);
    rd(8'h1C, 32'h10);
    ext_u.strobe(0);
    ext_u.strobe(0);
    rd(8'h1C, 32'h41);
    cnt(strig_cnt - t0, 0);
  endtask
  initial
  begin
    CLK = 1'b0;
    RSTN = 1'b0;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    repeat (10)
      @(posedge CLK);
    RSTN <= 1'b1;
    s_regs();
    s_post();
    s_src();
    s_pre();
    print_verdict();
  end
endmodule
